/* File: irq_wake_ctrl.sv */
`timescale 1ns/10ps

// What this block does
// - trap is taken at the next boundary whatever the mask bit says
// - external vector taken only when its event occurred and mask is clear
// - external requests raise the halt wake output
// - each external line's sensitivity comes from a software register
// - edge events latch; latch clears when the vector is fetched
// - enabled pins of one group are nanded before detection
// - a low enabled pin blocks the group, even for rising edge
// - peripheral flag interrupts only with mask clear and enable set
// - masked or disabled peripheral flags stay pending
// - writing zero to a flag bit clears that flag
// - status read with flag set then associated access clears flag
// - clearing sequence drops a pending disabled request
// - vector 1 shared by timebase and security; trap above all vectors
// - external lines use vectors 2 to 5 and can exit halt
// - vectors 7 to 11 serve the peripherals, no halt exit
// - clock vector exits active halt only
// - wait stops the cpu while peripherals keep running
// - entering wait clears the mask bit
// - wait lasts until an interrupt, then the vector is taken
// - service pushes four registers, then sets mask and fetches vector in one cycle
// - return from interrupt clears the mask bit
// - mask bit is set after reset
module irq_wake_ctrl (
    input  wire logic        CLOCK,
    input  wire logic        ARST_N,
    input  wire logic        S_AXI_AWVALID,
    output      logic        S_AXI_AWREADY,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_WVALID,
    output      logic        S_AXI_WREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    output      logic        S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    output      logic [1:0]  S_AXI_BRESP,
    input  wire logic        S_AXI_ARVALID,
    output      logic        S_AXI_ARREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    output      logic        S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output      logic [31:0] S_AXI_RDATA,
    output      logic [1:0]  S_AXI_RRESP,
    input  wire logic [15:0] EXT_PIN_LEVEL,
    input  wire logic [6:0]  SRC_EVENT,
    input  wire logic        CPU_BOUNDARY,
    input  wire logic        CPU_TRAP,
    input  wire logic        WAIT_FOR_IRQ_INSTR,
    input  wire logic        RETURN_FROM_IRQ_INSTR,
    input  wire logic        CPU_MASK_SET,
    input  wire logic        CPU_MASK_CLR,
    input  wire logic        HALT_MODE,
    input  wire logic        ACTIVE_HALT,
    output      logic        MASK_BIT,
    output      logic        CPU_STOPPED,
    output      logic        STACK_PUSH,
    output      logic [1:0]  STACK_SEL,
    output      logic        VEC_LOAD,
    output      logic [15:0] VEC_ADDR,
    output      logic        HALT_WAKE
);

    irq_wake_pkg::st_s st_q;
    irq_wake_pkg::st_s st_d;

    logic [3:0]  ext_lvl;
    logic [3:0]  ext_edge;
    logic [3:0]  ext_lreq;
    logic [3:0]  ext_req;
    logic        clk_req;
    logic [4:0]  per_req;
    logic [11:0] req;
    logic        take;
    logic        wr_go;
    logic        rd_go;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!ARST_N);

    // external groups: nand of enabled pins, then edge or level detector
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            logic       any;
            logic [1:0] s;
            any = |st_q.pen[4*i +: 4];
            s = st_q.sens[2*i +: 2];
            ext_lvl[i] = irq_wake_pkg::grp_level(EXT_PIN_LEVEL[4*i +: 4],
                                                 st_q.pen[4*i +: 4]);
            ext_lreq[i] = any && (s == irq_wake_pkg::SENS_LOW)
                          && !ext_lvl[i];
            // a low pin pins the nand high, so no rising edge can form
            ext_edge[i] = any && (
                ((s == irq_wake_pkg::SENS_RISE
                  || s == irq_wake_pkg::SENS_BOTH)
                 && ext_lvl[i] && !st_q.prev[i])
                || ((s == irq_wake_pkg::SENS_FALL
                     || s == irq_wake_pkg::SENS_BOTH)
                    && !ext_lvl[i] && st_q.prev[i]));
        end
    end

    // request vector, bit n is vector n and bit 0 the trap
    assign ext_req = st_q.latch | ext_lreq;
    assign clk_req = (st_q.flags[irq_wake_pkg::BIT_TB]
                      && st_q.en[irq_wake_pkg::BIT_TB])
                     || (st_q.flags[irq_wake_pkg::BIT_SEC]
                         && st_q.en[irq_wake_pkg::BIT_SEC]);
    assign per_req = st_q.flags[4:0] & st_q.en[4:0];
    assign req = {per_req & {5{!st_q.mask}}, 1'b0,
                  ext_req & {4{!st_q.mask}},
                  clk_req && !st_q.mask, st_q.trap};
    // trap bypasses the mask; the cpu cannot run a trap while stopped
    assign take = ((st_q.fsm == irq_wake_pkg::ST_RUN) && CPU_BOUNDARY
                   && (|req))
                  || ((st_q.fsm == irq_wake_pkg::ST_WAIT)
                      && (|req[11:1]));

    // halt exit uses raw requests since halt entry clears the mask
    assign HALT_WAKE = HALT_MODE && ((|ext_req)
                       || (ACTIVE_HALT && clk_req));

    assign wr_go = st_q.aw_got && st_q.w_got && !st_q.bvalid;
    assign rd_go = S_AXI_ARVALID && !st_q.rvalid;

    // all next-state logic: bus slave, sources, sequencer
    always_comb begin
        logic       seq;
        logic [6:0] ev;
        seq = 1'b0;
        ev = SRC_EVENT;
        st_d = st_q;
        st_d.push = 1'b0;
        st_d.load = 1'b0;
        st_d.prev = ext_lvl;

        // write channel capture, either order
        if (S_AXI_AWVALID && !st_q.aw_got) begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !st_q.w_got) begin
            st_d.w_got = 1'b1;
            st_d.wdata = S_AXI_WDATA;
            st_d.wstrb = S_AXI_WSTRB;
        end
        if (st_q.bvalid && S_AXI_BREADY) begin
            st_d.bvalid = 1'b0;
        end

        // register write once both halves are held
        if (wr_go) begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = irq_wake_pkg::RESP_OKAY;
            if (st_q.awaddr == irq_wake_pkg::OFS_EXT_SENS) begin
                if (st_q.wstrb[0]) begin
                    st_d.sens = st_q.wdata[7:0];
                    st_d.latch = 4'h0; // retuning drops stale edges
                end
            end else if (st_q.awaddr == irq_wake_pkg::OFS_PIN_EN) begin
                if (st_q.wstrb[0]) begin
                    st_d.pen[7:0] = st_q.wdata[7:0]
                                    & irq_wake_pkg::PIN_EN_MASK[7:0];
                end
                if (st_q.wstrb[1]) begin
                    st_d.pen[15:8] = st_q.wdata[15:8]
                                     & irq_wake_pkg::PIN_EN_MASK[15:8];
                end
            end else if (st_q.awaddr == irq_wake_pkg::OFS_SRC_EN) begin
                if (st_q.wstrb[0]) begin
                    st_d.en = st_q.wdata[6:0];
                end
            end else if (st_q.awaddr == irq_wake_pkg::OFS_SRC_FLAG) begin
                if (st_q.wstrb[0]) begin
                    st_d.flags = st_q.flags & st_q.wdata[6:0];
                end
            end else if (st_q.awaddr == irq_wake_pkg::OFS_SRC_DATA) begin
                seq = 1'b1;
            end else if (st_q.awaddr != irq_wake_pkg::OFS_CORE) begin
                st_d.bresp = irq_wake_pkg::RESP_SLVERR;
            end
        end

        // register read, answered one cycle after the address
        if (st_q.rvalid && S_AXI_RREADY) begin
            st_d.rvalid = 1'b0;
        end
        if (rd_go) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = irq_wake_pkg::RESP_OKAY;
            st_d.rdata = 32'h0000_0000;
            if (S_AXI_ARADDR == irq_wake_pkg::OFS_EXT_SENS) begin
                st_d.rdata[7:0] = st_q.sens;
            end else if (S_AXI_ARADDR == irq_wake_pkg::OFS_PIN_EN) begin
                st_d.rdata[15:0] = st_q.pen;
            end else if (S_AXI_ARADDR == irq_wake_pkg::OFS_SRC_EN) begin
                st_d.rdata[6:0] = st_q.en;
            end else if (S_AXI_ARADDR == irq_wake_pkg::OFS_SRC_FLAG) begin
                st_d.rdata[6:0] = st_q.flags;
                st_d.armed = st_q.flags;
            end else if (S_AXI_ARADDR == irq_wake_pkg::OFS_SRC_DATA) begin
                seq = 1'b1;
            end else if (S_AXI_ARADDR == irq_wake_pkg::OFS_CORE) begin
                st_d.rdata[irq_wake_pkg::CORE_MASK_BIT] = st_q.mask;
                st_d.rdata[irq_wake_pkg::CORE_FSM_LSB +: 2] = st_q.fsm;
                st_d.rdata[irq_wake_pkg::CORE_TRAP_BIT] = st_q.trap;
                st_d.rdata[irq_wake_pkg::CORE_LATCH_LSB +: 4] = st_q.latch;
            end else begin
                st_d.rresp = irq_wake_pkg::RESP_SLVERR;
            end
        end

        // clearing sequence drops the armed flags even if disabled
        if (seq) begin
            st_d.flags = st_d.flags & ~st_q.armed;
            st_d.armed = 7'h00;
        end
        // flags hold until cleared; a new event beats any clear
        st_d.flags = st_d.flags | ev;
        st_d.armed = st_d.armed & st_d.flags;

        // mask bit control from the core
        if (CPU_MASK_SET) begin
            st_d.mask = 1'b1;
        end
        if (CPU_MASK_CLR || RETURN_FROM_IRQ_INSTR) begin
            st_d.mask = 1'b0;
        end

        // service sequencer
        case (st_q.fsm)
            irq_wake_pkg::ST_RUN: begin
                if (take) begin
                    st_d.fsm = irq_wake_pkg::ST_PUSH;
                    st_d.vsel = irq_wake_pkg::pick(req);
                    st_d.cnt = 2'h0;
                end else if (WAIT_FOR_IRQ_INSTR) begin
                    st_d.fsm = irq_wake_pkg::ST_WAIT;
                    st_d.mask = 1'b0;
                end
            end
            irq_wake_pkg::ST_PUSH: begin
                st_d.push = 1'b1;
                st_d.psel = st_q.cnt;
                st_d.cnt = st_q.cnt + 2'h1;
                if (st_q.cnt == irq_wake_pkg::PUSH_LAST) begin
                    st_d.fsm = irq_wake_pkg::ST_FETCH;
                end
            end
            irq_wake_pkg::ST_FETCH: begin
                st_d.mask = 1'b1;
                st_d.load = 1'b1;
                st_d.vaddr = irq_wake_pkg::vec_addr(st_q.vsel);
                st_d.fsm = irq_wake_pkg::ST_RUN;
                if (st_q.vsel == irq_wake_pkg::VEC_TRAP) begin
                    st_d.trap = 1'b0;
                end
                for (int i = 0; i < 4; i++) begin
                    if (st_q.vsel == irq_wake_pkg::VEC_EXT0 + 4'(i)) begin
                        st_d.latch[i] = 1'b0;
                    end
                end
            end
            irq_wake_pkg::ST_WAIT: begin
                // only the cpu is stopped; sources and bus keep going
                if (take) begin
                    st_d.fsm = irq_wake_pkg::ST_PUSH;
                    st_d.vsel = irq_wake_pkg::pick(req);
                    st_d.cnt = 2'h0;
                end
            end
            default: begin
                st_d.fsm = irq_wake_pkg::ST_RUN;
            end
        endcase

        // set wins over clear for the trap and edge latches
        if (CPU_TRAP) begin
            st_d.trap = 1'b1;
        end
        st_d.latch = st_d.latch | ext_edge;
    end

    // the whole state in one register
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_q <= irq_wake_pkg::ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs
    assign S_AXI_AWREADY = !st_q.aw_got;
    assign S_AXI_WREADY  = !st_q.w_got;
    assign S_AXI_BVALID  = st_q.bvalid;
    assign S_AXI_BRESP   = st_q.bresp;
    assign S_AXI_ARREADY = !st_q.rvalid;
    assign S_AXI_RVALID  = st_q.rvalid;
    assign S_AXI_RDATA   = st_q.rdata;
    assign S_AXI_RRESP   = st_q.rresp;
    assign MASK_BIT      = st_q.mask;
    assign CPU_STOPPED   = (st_q.fsm == irq_wake_pkg::ST_WAIT);
    assign STACK_PUSH    = st_q.push;
    assign STACK_SEL     = st_q.psel;
    assign VEC_LOAD      = st_q.load;
    assign VEC_ADDR      = st_q.vaddr;

    // service walk: four pushes then a vector load
    sequence push_walk_s;
        ##1 STACK_PUSH [*4] ##1 VEC_LOAD;
    endsequence

    sequence load_done_s;
        VEC_LOAD && MASK_BIT;
    endsequence

    service_walk_a: assert property (
        take |=> push_walk_s ##0 load_done_s)
        else $error("service walk is not four pushes and a load");

    trap_unmasked_a: assert property (
        (st_q.fsm == irq_wake_pkg::ST_RUN) && CPU_BOUNDARY && st_q.trap
        |=> (st_q.fsm == irq_wake_pkg::ST_PUSH)
            && (st_q.vsel == irq_wake_pkg::VEC_TRAP))
        else $error("pending trap not taken at boundary");

    masked_ext_a: assert property (
        st_q.mask && (st_q.fsm == irq_wake_pkg::ST_RUN)
        |=> !((st_q.fsm == irq_wake_pkg::ST_PUSH)
              && (st_q.vsel != irq_wake_pkg::VEC_TRAP)))
        else $error("maskable vector taken with mask set");

    halt_exit_a: assert property (
        HALT_MODE && (|ext_req) |-> HALT_WAKE)
        else $error("external request did not wake halt");

    clk_halt_a: assert property (
        HALT_MODE && !ACTIVE_HALT && (ext_req == 4'h0) |-> !HALT_WAKE)
        else $error("non external source woke plain halt");

    edge_latch_a: assert property (
        ext_edge[0] |=> st_q.latch[0] [*2])
        else $error("external edge not held in latch");

    rise_block_a: assert property (
        (st_q.sens[1:0] == irq_wake_pkg::SENS_RISE) && st_q.pen[0]
        && !EXT_PIN_LEVEL[0] |-> !ext_edge[0])
        else $error("rising edge seen through a low pin");

    flag_pend_a: assert property (
        st_q.flags[0] && !wr_go && !rd_go |=> st_q.flags[0])
        else $error("pending flag lost without a clear");

    flag_wr0_a: assert property (
        wr_go && (st_q.awaddr == irq_wake_pkg::OFS_SRC_FLAG)
        && st_q.wstrb[0] && !st_q.wdata[0] && !SRC_EVENT[0]
        |=> !st_q.flags[0] && S_AXI_BVALID)
        else $error("write of zero did not clear flag");

    seq_clear_a: assert property (
        st_q.armed[1] && !SRC_EVENT[1]
        && ((wr_go && (st_q.awaddr == irq_wake_pkg::OFS_SRC_DATA))
            || (rd_go && (S_AXI_ARADDR == irq_wake_pkg::OFS_SRC_DATA)))
        |=> !st_q.flags[1])
        else $error("clearing sequence kept the flag");

    vec_table_a: assert property (
        VEC_LOAD |-> VEC_ADDR
                     == irq_wake_pkg::vec_addr($past(st_q.vsel)))
        else $error("vector address does not match table");

    wait_entry_a: assert property (
        (st_q.fsm == irq_wake_pkg::ST_RUN) && WAIT_FOR_IRQ_INSTR && !take
        |=> CPU_STOPPED && !MASK_BIT)
        else $error("wait entry left mask set");

endmodule

/* File: irq_wake_pkg.sv */
package irq_wake_pkg;

    // core sequencer states, gray along run -> push -> fetch
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_PUSH  = 2'b01,
        ST_FETCH = 2'b11,
        ST_WAIT  = 2'b10
    } fsm_e;

    // register byte offsets
    localparam logic [7:0] OFS_EXT_SENS = 8'h00;
    localparam logic [7:0] OFS_PIN_EN   = 8'h04;
    localparam logic [7:0] OFS_SRC_EN   = 8'h08;
    localparam logic [7:0] OFS_SRC_FLAG = 8'h0C;
    localparam logic [7:0] OFS_SRC_DATA = 8'h10;
    localparam logic [7:0] OFS_CORE     = 8'h14;

    // sensitivity codes, two bits per external line
    localparam logic [1:0] SENS_LOW  = 2'h0;
    localparam logic [1:0] SENS_RISE = 2'h1;
    localparam logic [1:0] SENS_FALL = 2'h2;
    localparam logic [1:0] SENS_BOTH = 2'h3;

    // source bit positions in enable and flag registers
    localparam int BIT_TB  = 5;
    localparam int BIT_SEC = 6;
    localparam int NSRC    = 7;

    // core status field positions
    localparam int CORE_MASK_BIT  = 0;
    localparam int CORE_FSM_LSB   = 1;
    localparam int CORE_TRAP_BIT  = 3;
    localparam int CORE_LATCH_LSB = 4;

    // vector numbers and addresses
    localparam logic [3:0]  VEC_TRAP   = 4'h0;
    localparam logic [3:0]  VEC_CLK    = 4'h1;
    localparam logic [3:0]  VEC_EXT0   = 4'h2;
    localparam logic [3:0]  VEC_SPI    = 4'h7;
    localparam logic [15:0] ADDR_RESET = 16'hFFFE;
    localparam logic [15:0] ADDR_TRAP  = 16'hFFFC;
    localparam logic [15:0] ADDR_BASE  = 16'hFFFA;

    // stacking pushes pc, x, a, condition codes: last word index
    localparam logic [1:0] PUSH_LAST = 2'h3;

    // reset values and writable bit masks
    localparam logic [7:0]  RST_SENS    = 8'h00;
    localparam logic [15:0] PIN_EN_MASK = 16'hFF7F;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        fsm_e        fsm;
        logic        mask;
        logic        trap;
        logic [1:0]  cnt;
        logic [3:0]  vsel;
        logic        push;
        logic [1:0]  psel;
        logic        load;
        logic [15:0] vaddr;
        logic [7:0]  sens;
        logic [15:0] pen;
        logic [6:0]  en;
        logic [6:0]  flags;
        logic [6:0]  armed;
        logic [3:0]  prev;
        logic [3:0]  latch;
        logic        aw_got;
        logic [7:0]  awaddr;
        logic        w_got;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } st_s;

    localparam st_s ST_RST = '{fsm: ST_RUN, mask: 1'b1, sens: RST_SENS,
                               default: '0};

    // vector number to fetch address; number zero stands for the trap
    function automatic logic [15:0] vec_addr(input logic [3:0] n);
        vec_addr = (n == VEC_TRAP) ? ADDR_TRAP
                                   : ADDR_BASE - {11'h000, n, 1'b0};
    endfunction

    // nand of enabled pins, inverted: high only while all enabled are high
    function automatic logic grp_level(input logic [3:0] pins,
                                       input logic [3:0] en);
        grp_level = &(pins | ~en);
    endfunction

    // lowest set bit wins: trap, then vectors in ascending number
    function automatic logic [3:0] pick(input logic [11:0] req);
        pick = VEC_TRAP;
        for (int i = 11; i >= 0; i--) begin
            if (req[i]) begin
                pick = 4'(i);
            end
        end
    endfunction

endpackage

/* File: core_model.sv */
`timescale 1ns/10ps

// core stand-in: offers a boundary every cycle while RUN is high and
// tracks the pushes that come ahead of each vector fetch
module core_model (
    input  wire logic       CLOCK,
    input  wire logic       ARST_N,
    input  wire logic       RUN,
    input  wire logic       STACK_PUSH,
    input  wire logic [1:0] STACK_SEL,
    output      logic       CPU_BOUNDARY,
    output      logic [7:0] PUSH_CNT,
    output      logic       ORDER_BAD
);
    // one-cycle instructions, the fastest a core can retire, so that
    // boundaries land inside the stacking window as well
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            CPU_BOUNDARY <= 1'b0;
            PUSH_CNT     <= 8'h00;
            ORDER_BAD    <= 1'b0;
        end else begin
            CPU_BOUNDARY <= RUN;
            if (STACK_PUSH) begin
                PUSH_CNT <= PUSH_CNT + 8'h01;
                // words come pc, x, a, condition codes; gaps show here
                if (STACK_SEL != PUSH_CNT[1:0]) begin
                    ORDER_BAD <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: mcu_interrupt_and_wait_wake_tb_top.sv */
`timescale 1ns/10ps

module mcu_interrupt_and_wait_wake_tb_top;
    logic        clk    = 1'b0;
    logic        arst_n = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [15:0] pins = 16'hFFFF;
    logic [6:0]  ev = 7'h00;
    logic        trap = 1'b0, idle = 1'b0, ret = 1'b0, mset = 1'b0;
    logic        hm = 1'b0, ah = 1'b0, run = 1'b0;
    logic        awr, wr, bv, arr, rv, mask, stopped, push, vload, wake;
    logic        bnd, obad;
    logic [1:0]  br, rr, sel;
    logic [31:0] rd;
    logic [15:0] vaddr;
    logic [7:0]  pcnt;
    int          error_cnt = 0, total_checks = 0;

    // rows 0..6 are flag sources, rows 7..10 external lines 0..3
    localparam logic [15:0] ROW_VEC [11] = '{16'hFFEC, 16'hFFEA, 16'hFFE8,
        16'hFFE6, 16'hFFE4, 16'hFFF8, 16'hFFF8, 16'hFFF6, 16'hFFF4,
        16'hFFF2, 16'hFFF0};
    localparam logic [10:0] ROW_WAKE_H = 11'h780;
    localparam logic [10:0] ROW_WAKE_A = 11'h7E0;

    always #5 clk = ~clk;

    // bready and rready stay high: the bench never stalls answers
    irq_wake_ctrl uut (
        .CLOCK(clk), .ARST_N(arst_n),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1),
        .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1),
        .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .EXT_PIN_LEVEL(pins),
        .SRC_EVENT(ev), .CPU_BOUNDARY(bnd), .CPU_TRAP(trap),
        .WAIT_FOR_IRQ_INSTR(idle), .RETURN_FROM_IRQ_INSTR(ret),
        .CPU_MASK_SET(mset), .CPU_MASK_CLR(1'b0), .HALT_MODE(hm),
        .ACTIVE_HALT(ah), .MASK_BIT(mask), .CPU_STOPPED(stopped),
        .STACK_PUSH(push), .STACK_SEL(sel), .VEC_LOAD(vload),
        .VEC_ADDR(vaddr), .HALT_WAKE(wake)
    );

    core_model core (
        .CLOCK(clk), .ARST_N(arst_n), .RUN(run), .STACK_PUSH(push),
        .STACK_SEL(sel), .CPU_BOUNDARY(bnd), .PUSH_CNT(pcnt),
        .ORDER_BAD(obad)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // a bounded wait ran out
    task automatic hang;
        error_cnt++;
        complete_run();
    endtask

    // ready is stable from the negedge to the edge that takes the item
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic da, dw, ta, tw, got;
        da = 1'b0;
        dw = 1'b0;
        got = 1'b0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        for (int n = 0; !(da && dw); n++) begin
            if (n > 50) hang();
            @(negedge clk);
            ta = !da && awr;
            tw = !dw && wr;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            da = da || ta;
            dw = dw || tw;
        end
        for (int n = 0; !got; n++) begin
            if (n > 50) hang();
            @(negedge clk);
            got = bv;
            @(posedge clk);
        end
        chk(br, irq_wake_pkg::RESP_OKAY);
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        logic got;
        got = 1'b0;
        ara <= a;
        arv <= 1'b1;
        for (int n = 0; !got; n++) begin
            if (n > 50) hang();
            @(negedge clk);
            got = arr;
            @(posedge clk);
        end
        arv <= 1'b0;
        got = 1'b0;
        for (int n = 0; !got; n++) begin
            if (n > 50) hang();
            @(negedge clk);
            got = rv;
            d = rd;
            r = rr;
            @(posedge clk);
        end
    endtask

    task automatic waitvec(input int lim, output logic got);
        got = 1'b0;
        for (int n = 0; n < lim && !got; n++) begin
            @(negedge clk);
            got = (vload === 1'b1);
            @(posedge clk);
        end
    endtask

    task automatic take(input logic [15:0] exp);
        logic       got;
        logic [7:0] p0;
        p0 = pcnt;
        waitvec(40, got);
        if (!got) hang();
        chk(vaddr, exp);
        chk(mask, 1'b1);
        chk(pcnt - p0, 8'h04);
        chk(obad, 1'b0);
    endtask

    task automatic notake;
        logic got;
        waitvec(20, got);
        chk(got, 1'b0);
    endtask

    initial begin : main
        logic [31:0] d;
        logic [1:0]  r;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk(mask, 1'b1);
        chk(stopped, 1'b0);
        @(posedge clk);
        // trap and timebase together: trap first, timebase kept
        axw(irq_wake_pkg::OFS_SRC_EN, 32'h1 << irq_wake_pkg::BIT_TB);
        ev <= 7'h01 << irq_wake_pkg::BIT_TB;
        trap <= 1'b1;
        ret <= 1'b1;
        run <= 1'b1;
        @(posedge clk);
        ev <= 7'h00;
        trap <= 1'b0;
        ret <= 1'b0;
        take(16'hFFFC);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        take(16'hFFF8);
        // trap with the mask set still goes through
        trap <= 1'b1;
        @(posedge clk);
        trap <= 1'b0;
        take(16'hFFFC);
        run <= 1'b0;
        axw(irq_wake_pkg::OFS_SRC_FLAG, 32'h0);
        axw(irq_wake_pkg::OFS_PIN_EN, 32'h0000FF7F);
        // one row per vector source, low-level sensitivity for pins
        for (int i = 0; i < 11; i++) begin
            if (i < 7) begin
                axw(irq_wake_pkg::OFS_SRC_EN, 32'(1) << i);
                ev <= 7'(1 << i);
                @(posedge clk);
                ev <= 7'h00;
            end else begin
                pins <= ~(16'h0001 << (4 * (i - 7)));
            end
            hm <= 1'b1;
            @(posedge clk);
            @(negedge clk);
            chk(wake, ROW_WAKE_H[i]);
            @(posedge clk);
            ah <= 1'b1;
            @(negedge clk);
            chk(wake, ROW_WAKE_A[i]);
            @(posedge clk);
            hm <= 1'b0;
            ah <= 1'b0;
            ret <= 1'b1;
            run <= 1'b1;
            @(posedge clk);
            ret <= 1'b0;
            take(ROW_VEC[i]);
            run <= 1'b0;
            pins <= 16'hFFFF;
            axw(irq_wake_pkg::OFS_SRC_FLAG, 32'h0);
            axr(irq_wake_pkg::OFS_SRC_FLAG, d, r);
            chk(d, 32'h0);
        end
        // disabled flag stays pending, then a clearing sequence drops it
        axw(irq_wake_pkg::OFS_SRC_EN, 32'h0);
        ev <= 7'h02;
        @(posedge clk);
        ev <= 7'h00;
        ret <= 1'b1;
        run <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        notake();
        axr(irq_wake_pkg::OFS_SRC_FLAG, d, r);
        chk(d, 32'h2);
        axr(irq_wake_pkg::OFS_SRC_DATA, d, r);
        axr(irq_wake_pkg::OFS_SRC_FLAG, d, r);
        chk(d, 32'h0);
        axw(irq_wake_pkg::OFS_SRC_EN, 32'h2);
        notake();
        // rising edge on line 0 while another enabled pin holds low
        axw(irq_wake_pkg::OFS_EXT_SENS, 32'h1);
        pins <= 16'hFFFD;
        @(posedge clk);
        pins <= 16'hFFFC;
        @(posedge clk);
        pins <= 16'hFFFD;
        notake();
        pins <= 16'hFFFF;
        take(16'hFFF6);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        notake();
        // wait mode: mask dropped, registers kept, event wakes
        run <= 1'b0;
        axw(irq_wake_pkg::OFS_SRC_EN, 32'h4);
        mset <= 1'b1;
        @(posedge clk);
        mset <= 1'b0;
        idle <= 1'b1;
        @(posedge clk);
        idle <= 1'b0;
        @(negedge clk);
        chk(stopped, 1'b1);
        chk(mask, 1'b0);
        @(posedge clk);
        axr(irq_wake_pkg::OFS_SRC_EN, d, r);
        chk(d, 32'h4);
        ev <= 7'h04;
        @(posedge clk);
        ev <= 7'h00;
        take(16'hFFE8);
        @(negedge clk);
        chk(stopped, 1'b0);
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk(mask, 1'b1);
        chk(vaddr, 16'h0);
        @(posedge clk);
        // unmapped address answers with an error and zero data
        axr(8'h40, d, r);
        chk(r, irq_wake_pkg::RESP_SLVERR);
        chk(d, 32'h0);
        complete_run();
    end
endmodule
